//--- charge_seq_pkg.sv
/*
  constants, register map and carrier types of the charge sequencer.
  assumes a 40 MHz pclk and an APB master with 32-bit data.
*/
`default_nettype none
package charge_seq_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS         = 1_000_000;
  localparam int TICK_CYC      = MS_NS / CLK_PERIOD_NS;
  localparam int DBT_MIN       = 30;
  localparam int TOPOFF_MIN    = 30;
  localparam int MIN_MS        = 60_000;
  localparam int HOUR_MS       = 3_600_000;
  localparam int DBT_MS        = DBT_MIN * MIN_MS;
  localparam int TOPOFF_MS     = TOPOFF_MIN * MIN_MS;
  localparam int TOTAL_BASE_H  = 5;
  localparam int DEBOUNCE_MS   = 60;
  localparam int MS_W          = 26;
  // ------------------------------------------------------------
  // currents in mA
  // ------------------------------------------------------------
  localparam logic [10:0] PRE_MA    = 11'd90;
  localparam logic [10:0] LEVEL_BASE_MA = 11'd200;
  localparam logic [10:0] LEVEL_STEP_MA = 11'd50;
  localparam logic [10:0] RAMP_MA   = 11'd10;
  // ------------------------------------------------------------
  // register map (byte addresses) and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_LEVEL  = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_EVENT  = 8'h0C;
  localparam logic [9:0]  CTRL_RST  = 10'h057;
  localparam logic [15:0] LEVEL_RST = 16'h8A35;
  // ctrl bit positions
  localparam int C_EN = 0, C_DBT = 1, C_TOT = 2, C_TOP = 3, C_STOP = 4;
  localparam int C_FORCE = 5, C_AUTO = 6, C_LEN = 8;
  // event bit positions
  localparam int E_DBT = 0, E_TOT = 1, E_HOT = 2, E_TERM = 3, E_RECH = 4;
  localparam int EVENT_W = 5;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001, ST_PRE  = 7'b000_0010, ST_FAST = 7'b000_0100,
    ST_CV   = 7'b000_1000, ST_TOP  = 7'b001_0000, ST_DONE = 7'b010_0000,
    ST_FAULT = 7'b100_0000
  } state_e;
  typedef enum logic [2:0] {
    ACC_NONE = 3'd0, ACC_SDP = 3'd1, ACC_CDP = 3'd2, ACC_DCP = 3'd3,
    ACC_CARKIT = 3'd4, ACC_FACTORY = 3'd5, ACC_UNKNOWN = 3'd6
  } accessory_e;
  typedef struct packed {
    logic supply_valid;
    logic over_voltage;
    logic battery_absent_input;
    logic over_temp;
    logic below_short;
    logic below_weak;
    logic near_float;
    logic below_end;
    logic recharge_drop;
  } sense_s;
  typedef struct packed {
    logic        charge_on;
    logic        voltage_loop;
    logic [10:0] current_ma;
  } drive_s;
  typedef struct packed {
    logic [3:0] weak_battery_level;
    logic [3:0] float_voltage_level;
    logic [3:0] end_of_charge_level;
    logic [3:0] fast_charge_level;
  } level_s;
endpackage
`default_nettype wire

//--- charge_seq.sv
/*
  linear li-ion charge sequencer with APB register slave.
  assumes analog comparators deliver the sense inputs synchronous to
  pclk and an accessory detector gives the attached accessory type.
*/
`timescale 1ns/100ps
`default_nettype none
module charge_seq
  import charge_seq_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int DBT_LIMIT   = DBT_MS,
  parameter int TOP_LIMIT   = TOPOFF_MS,
  parameter int HOUR_LIMIT  = HOUR_MS
) (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // analog side
  input  wire sense_s      sense,
  input  wire accessory_e  accessory,
  output var  drive_s      drive,
  output var  level_s      levels,
  output var  state_e      state
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [9:0]         ctrl_r;
  logic [EVENT_W-1:0] event_r;
  logic [15:0]        tick_cnt_r;
  logic               tick;
  logic [MS_W-1:0]    dbt_ms_r, tot_ms_r, top_ms_r;
  logic [6:0]         deb_ms_r;
  logic               term_seen_r, dbt_live_r;
  logic               dbt_exp, tot_exp, top_exp, deb_done;
  logic [10:0]        target_ma;
  state_e             state_nxt;
  logic               restart;
  logic               fault_entry;
  logic               setup, wr_en;

  // total timer limit in ms from the programmed length
  function automatic logic [MS_W-1:0] total_limit(input logic [1:0] len);
    total_limit = MS_W'((TOTAL_BASE_H + int'(len)) * HOUR_LIMIT);
  endfunction

  // fast-charge level code to mA
  function automatic logic [10:0] level_ma(input logic [3:0] lv);
    level_ma = 11'(LEVEL_BASE_MA + LEVEL_STEP_MA * 11'(lv));
  endfunction

  // ------------------------------------------------------------
  // apb slave: data is latched in setup so every output is a flop
  // ------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;

  // answer one cycle after setup: zero wait states in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (setup) begin
        case (paddr)
          A_CTRL:   prdata <= {22'h0, ctrl_r};
          A_LEVEL:  prdata <= {16'h0, levels};
          A_STATUS: prdata <= {5'h0, drive.current_ma, 6'h00, drive.charge_on,
                               drive.voltage_loop, term_seen_r, state};
          A_EVENT:  prdata <= {27'h0, event_r};
          default:  pslverr <= 1'b1;
        endcase
      end
    end
  end

  // control and level registers; disable then enable clears a fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      levels <= LEVEL_RST;
    end else if (ce && wr_en) begin
      if (paddr == A_CTRL)
        ctrl_r <= pwdata[9:0];
      if (paddr == A_LEVEL)
        levels <= pwdata[15:0];
    end
  end

  // faults flag once on entry, so a cause that stands in fault cannot defeat the clear
  assign fault_entry = state_nxt == ST_FAULT && state != ST_FAULT;

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_r <= '0;
    end else if (ce) begin
      event_r <= (event_r & ~((wr_en && paddr == A_EVENT) ? pwdata[EVENT_W-1:0] : '0))
               | {state_nxt == ST_FAST && state == ST_DONE,
                  state_nxt == ST_DONE && state == ST_CV || top_exp && state == ST_TOP,
                  fault_entry && sense.over_temp,
                  fault_entry && tot_exp,
                  fault_entry && dbt_exp};
    end
  end

  // ------------------------------------------------------------
  // millisecond tick and timers
  // ------------------------------------------------------------
  assign tick     = (tick_cnt_r == 16'(TICK_CYCLES - 1));
  assign dbt_exp  = dbt_live_r && ctrl_r[C_DBT] && dbt_ms_r >= MS_W'(DBT_LIMIT);
  assign tot_exp  = ctrl_r[C_TOT] && tot_ms_r >= total_limit(ctrl_r[C_LEN+:2]);
  assign top_exp  = top_ms_r >= MS_W'(TOP_LIMIT);
  assign deb_done = deb_ms_r >= 7'(DEBOUNCE_MS);
  assign restart  = state == ST_IDLE && state_nxt != ST_IDLE;

  // shared prescaler; restarts with each attach so timers start aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tick_cnt_r <= 16'h0000;
    else if (ce)
      tick_cnt_r <= (tick || restart) ? 16'h0000 : 16'(tick_cnt_r + 16'h0001);
  end

  // dead-battery timer: cleared only when a charge starts from idle, keeps running under ovp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbt_ms_r   <= '0;
      dbt_live_r <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        dbt_ms_r   <= '0;
        dbt_live_r <= 1'b1;
      end else if (!sense.below_weak || state == ST_IDLE) begin
        dbt_live_r <= 1'b0;
      end else if (tick && dbt_live_r) begin
        dbt_ms_r <= MS_W'(dbt_ms_r + 1'b1);
      end
    end
  end

  // total timer stops at termination and ignores top-off time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tot_ms_r    <= '0;
      term_seen_r <= 1'b0;
    end else if (ce) begin
      if (restart || state_nxt == ST_FAST && state == ST_DONE) begin
        tot_ms_r    <= '0;
        term_seen_r <= 1'b0;
      end else if (state == ST_CV && sense.below_end) begin
        term_seen_r <= 1'b1;
      end else if (tick && !term_seen_r && (state == ST_PRE || state == ST_FAST || state == ST_CV)) begin
        tot_ms_r <= MS_W'(tot_ms_r + 1'b1);
      end
    end
  end

  // top-off duration and recharge debounce
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_ms_r <= '0;
      deb_ms_r <= 7'h00;
    end else if (ce) begin
      if (state != ST_TOP)
        top_ms_r <= '0;
      else if (tick)
        top_ms_r <= MS_W'(top_ms_r + 1'b1);
      if (state != ST_DONE || !sense.recharge_drop)
        deb_ms_r <= 7'h00;
      else if (tick && !deb_done)
        deb_ms_r <= 7'(deb_ms_r + 7'h01);
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // next stage; loss of supply or enable wins over everything
  always_comb begin
    state_nxt = state;
    if (!sense.supply_valid || !ctrl_r[C_EN] || sense.battery_absent_input) begin
      state_nxt = ST_IDLE;
    end else if (state != ST_IDLE && state != ST_FAULT && sense.over_temp) begin
      state_nxt = ST_FAULT;
    end else if ((state == ST_PRE || state == ST_FAST) && dbt_exp) begin
      state_nxt = ST_FAULT;
    end else if ((state == ST_PRE || state == ST_FAST || state == ST_CV) && tot_exp && !term_seen_r) begin
      state_nxt = ST_FAULT;
    end else begin
      case (state)
        ST_IDLE:  state_nxt = sense.below_short ? ST_PRE : ST_FAST;
        ST_PRE:   if (!sense.below_short) state_nxt = ST_FAST;
        ST_FAST:  if (sense.near_float) state_nxt = ST_CV;
        ST_CV:    if (sense.below_end && ctrl_r[C_STOP])
                    state_nxt = ctrl_r[C_TOP] ? ST_TOP : ST_DONE;
        ST_TOP:   if (top_exp) state_nxt = ST_DONE;
        ST_DONE:  if (deb_done) state_nxt = ST_FAST;
        ST_FAULT: state_nxt = ST_FAULT;
        default:  state_nxt = ST_IDLE;
      endcase
    end
  end

  // stage register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state <= ST_IDLE;
    else if (ce)
      state <= state_nxt;
  end

  // current target for the present stage
  always_comb begin
    target_ma = 11'h000;
    case (state)
      ST_PRE: target_ma = PRE_MA;
      ST_FAST, ST_CV, ST_TOP: begin
        if (ctrl_r[C_FORCE])
          target_ma = level_ma(levels.fast_charge_level);
        else if (ctrl_r[C_AUTO] && (accessory == ACC_CDP || accessory == ACC_DCP
                                    || accessory == ACC_CARKIT))
          target_ma = level_ma(levels.fast_charge_level);
        else
          target_ma = PRE_MA;
      end
      default: target_ma = 11'h000;
    endcase
  end

  // soft start: up in steps on each tick, down at once; ovp pauses only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '0;
    end else if (ce) begin
      drive.voltage_loop <= state_nxt == ST_CV || state_nxt == ST_TOP;
      if (state_nxt == ST_IDLE || sense.over_voltage || target_ma == 11'h000) begin
        drive.charge_on  <= 1'b0;
        drive.current_ma <= 11'h000;
      end else begin
        drive.charge_on <= 1'b1;
        if (drive.current_ma > target_ma)
          drive.current_ma <= target_ma;
        else if (tick)
          drive.current_ma <= (target_ma - drive.current_ma > RAMP_MA)
                              ? 11'(drive.current_ma + RAMP_MA) : target_ma;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_pre_current: assert property (state == ST_PRE |-> target_ma == 11'd90)
    else $error("pre-charge target not 90 mA");
  chk_supply_loss: assert property (ce && !sense.supply_valid |=> state == ST_IDLE)
    else $error("no idle after supply loss");
  chk_absent_off: assert property (ce && sense.battery_absent_input |=> !drive.charge_on)
    else $error("charger on with battery absent");
  chk_ovp_pause: assert property (ce && sense.over_voltage |=> !drive.charge_on && drive.current_ma == 0)
    else $error("charging during over-voltage");
  chk_soft_ramp: assert property (ce |=> drive.current_ma <= $past(drive.current_ma) + 10)
    else $error("current stepped up too fast");
  chk_hot_fault: assert property (ce && state != ST_IDLE && state != ST_FAULT && sense.supply_valid
                                  && ctrl_r[C_EN] && !sense.battery_absent_input && sense.over_temp
                                  |=> state == ST_FAULT && event_r[E_HOT])
    else $error("overtemperature not handled");
  chk_dbt_expire: assert property (ce && state_nxt != ST_IDLE && state == ST_PRE && dbt_exp
                                   |=> state == ST_FAULT)
    else $error("dead-battery expiry ignored");
  chk_fast_select: assert property (state == ST_FAST && !ctrl_r[C_FORCE] && !ctrl_r[C_AUTO]
                                    |-> target_ma == PRE_MA)
    else $error("fast level without select");
  chk_debounce: assert property (ce && state == ST_DONE && state_nxt == ST_FAST
                                 |-> deb_ms_r == 60)
    else $error("recharge before debounce");
endmodule
`default_nettype wire

//--- pack_model.sv
/*
  behavioural usb source and li-ion pack that face the charge sequencer.
  assumes the bench steers attach, faults and load right after pclk edges.
*/
`timescale 1ns/100ps
`default_nettype none
module pack_model
  import charge_seq_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench controls
  input  wire logic       attach,
  input  wire logic       shorted,
  input  wire logic       hold,
  input  wire logic       ov,
  input  wire logic       hot,
  input  wire logic       absent,
  input  wire logic       load,
  input  wire accessory_e acc_in,
  // charger side
  input  wire drive_s     drive,
  output var  sense_s     sense,
  output var  accessory_e accessory
);
  // ------------------------------------------------------------
  // cell voltage
  // ------------------------------------------------------------
  int vbat_mv_r;

  // rises with charge current; hold parks it between weak and float so stages can be studied
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbat_mv_r <= 0;
    end else if (load) begin
      vbat_mv_r <= 3900;  // a heavy load pulls the cell well under float
    end else if (shorted) begin
      vbat_mv_r <= 0;
    end else if (drive.charge_on && !(hold && vbat_mv_r >= 3600) && vbat_mv_r < 4200) begin
      vbat_mv_r <= vbat_mv_r + int'(drive.current_ma) / 4 + 1;
    end
  end

  // comparators; no accessory is seen while the cable is out
  assign sense = '{attach, ov, absent, hot, vbat_mv_r < 2500, vbat_mv_r < 3400, vbat_mv_r >= 4150,
                   drive.voltage_loop && vbat_mv_r >= 4180, vbat_mv_r <= 4050};
  assign accessory = attach ? acc_in : ACC_NONE;
endmodule
`default_nettype wire

//--- tb_charge_seq.sv
/*
  self-checking bench: apb master, pack model and a read scoreboard.
  assumes shortened tick and timer parameters on the sequencer.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_charge_seq
  import charge_seq_pkg::*;
  ;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        attach, shorted, hold, ov, hot, absent, load;
  accessory_e  acc_in, accessory;
  sense_s      sense;
  drive_s      drive;
  level_s      levels;
  state_e      state;
  logic [32:0] exp_q[$];
  int          n_fail, samples_checked;
  int          cyc = 0;
  logic [3:0]  lv;
  logic [10:0] lvl_ma;
  logic [10:0] prev_ma = '0;

  charge_seq #(.TICK_CYCLES(4), .DBT_LIMIT(100), .TOP_LIMIT(20), .HOUR_LIMIT(200)) dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense(sense), .accessory(accessory), .drive(drive), .levels(levels), .state(state));
  pack_model pack (
    .pclk(pclk), .presetn(presetn), .attach(attach), .shorted(shorted), .hold(hold), .ov(ov),
    .hot(hot), .absent(absent), .load(load), .acc_in(acc_in), .drive(drive), .sense(sense),
    .accessory(accessory));

  // free-running clock
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  // ------------------------------------------------------------
  // checking and apb tasks
  // ------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // request held until pready is sampled high, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check(33'(pready), 33'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic wait_st(input state_e s);
    int n;
    n = 0;
    while (state !== s && n < 6000) begin
      @(posedge pclk);
      n++;
    end
    check(33'(state), 33'(s));
  endtask

  task automatic wait_cur(input logic [10:0] e);
    int n;
    n = 0;
    while (drive.current_ma !== e && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    check(33'(drive.current_ma), 33'(e));
  endtask

  // one row of the fast-charge selection table
  task automatic fc(input logic fo, input logic au, input accessory_e a, input logic [10:0] e);
    xfer(1'b1, A_CTRL, {22'h0, 3'b000, au, fo, 5'h17});
    acc_in <= a;
    wait_cur(e);
  endtask

  // scoreboard: each completed read meets the oldest note; current may only creep up
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) check(33'h0, 33'h1);
      else check({pslverr, prdata}, exp_q.pop_front());
    end
    if (presetn && drive.current_ma > prev_ma) check(33'(drive.current_ma - prev_ma <= RAMP_MA), 33'h1);
    prev_ma <= drive.current_ma;
  end

  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {attach, shorted, ov, hot, absent, load} = '0;
    hold = 1'b1;
    acc_in = ACC_DCP;
    n_fail = 0;
    samples_checked = 0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(64160));
    rd(A_CTRL, 33'h0057);
    rd(A_LEVEL, 33'h8A35);
    xfer(1'b1, A_STATUS, 32'hFFFF_FFFF);
    rd(A_STATUS, 33'h0001);
    rd(8'h10, 33'h1_0000_0000);
    check(33'(levels), 33'(LEVEL_RST));
    $display("done: registers");
    shorted <= 1'b1;
    attach <= 1'b1;
    wait_st(ST_PRE);
    wait_cur(PRE_MA);
    wait_st(ST_FAULT);
    rd(A_EVENT, 33'h0001);
    xfer(1'b1, A_EVENT, 32'h001F);
    rd(A_EVENT, 33'h0000);
    attach <= 1'b0;
    wait_st(ST_IDLE);
    attach <= 1'b1;
    wait_st(ST_PRE);
    repeat (100) @(posedge pclk);
    check(33'(state), 33'(ST_PRE));
    // software drops the dead-battery enable: the short must outlast the timer unharmed
    xfer(1'b1, A_CTRL, 32'h0000_0055);
    repeat (400) @(posedge pclk);
    check(33'(state), 33'(ST_PRE));
    shorted <= 1'b0;
    wait_st(ST_FAST);
    wait_cur(11'd450);
    rd(A_STATUS, 33'h01C2_0204);
    $display("done: dead battery");
    lv = 4'($urandom_range(15, 0));
    lvl_ma = 11'd200 + 11'd50 * 11'(lv);
    xfer(1'b1, A_LEVEL, {16'h0, 12'h8A3, lv});
    fc(1'b1, 1'b0, ACC_SDP, lvl_ma);
    fc(1'b0, 1'b0, ACC_DCP, PRE_MA);
    fc(1'b0, 1'b1, ACC_CDP, lvl_ma);
    fc(1'b0, 1'b1, ACC_SDP, PRE_MA);
    fc(1'b0, 1'b1, ACC_DCP, lvl_ma);
    fc(1'b0, 1'b1, ACC_UNKNOWN, PRE_MA);
    fc(1'b0, 1'b1, ACC_CARKIT, lvl_ma);
    fc(1'b0, 1'b1, ACC_FACTORY, PRE_MA);
    ov <= 1'b1;
    repeat (4) @(posedge pclk);
    check(33'(drive.charge_on), 33'h0);
    check(33'(state), 33'(ST_FAST));
    ov <= 1'b0;
    wait_st(ST_FAULT);
    rd(A_EVENT, 33'h0002);
    xfer(1'b1, A_EVENT, 32'h001F);
    $display("done: fast charge and total timer");
    xfer(1'b1, A_CTRL, 32'h0056);
    xfer(1'b1, A_CTRL, 32'h0057);
    hold <= 1'b0;
    wait_st(ST_FAST);
    wait_st(ST_CV);
    // looked at on cv entry: termination may follow within two cycles
    check(33'(drive.voltage_loop), 33'h1);
    wait_st(ST_DONE);
    rd(A_EVENT, 33'h0008);
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    repeat (200) @(posedge pclk);
    check(33'(state), 33'(ST_DONE));
    wait_st(ST_FAST);
    rd(A_EVENT, 33'h0018);
    xfer(1'b1, A_EVENT, 32'h001F);
    xfer(1'b1, A_CTRL, 32'h005F);
    wait_st(ST_TOP);
    repeat (60) @(posedge pclk);
    check(33'(state), 33'(ST_TOP));
    wait_st(ST_DONE);
    xfer(1'b1, A_CTRL, 32'h0047);
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    wait_st(ST_CV);
    repeat (400) @(posedge pclk);
    check(33'(state), 33'(ST_CV));
    $display("done: termination and recharge");
    absent <= 1'b1;
    wait_st(ST_IDLE);
    absent <= 1'b0;
    xfer(1'b1, A_EVENT, 32'h001F);
    hot <= 1'b1;
    wait_st(ST_FAULT);
    rd(A_EVENT, 33'h0004);
    attach <= 1'b0;
    wait_st(ST_IDLE);
    repeat (2) @(posedge pclk);
    check(33'(drive.charge_on), 33'h0);
    $display("done: faults");
    results();
  end
endmodule
`default_nettype wire
